/* File: rtl/asb_host.sv */
`default_nettype none
module asb_host #(
    parameter int TMO_CYC = 100
) (
    input  wire logic                     clk_in,
    input  wire logic                     nrst_in,
    input  wire logic                     init_req_in,
    input  wire logic                     req_valid_in,
    input  wire asb_pkg::asb_req_type     req_in,
    output logic                          req_ready_out,
    output logic                          done_out,
    output logic                          err_out,
    output logic [asb_pkg::DAL_W-1:0]     rdata_out,
    input  wire logic [15:0]              processor_status_word_in,
    output logic                          vec_valid_out,
    output logic [asb_pkg::DAL_W-1:0]     vec_out,
    output asb_pkg::asb_ctl_type          ctl_out,
    input  wire logic                     rply_n_in,
    input  wire logic                     irq_n_in,
    input  wire logic [asb_pkg::DAL_W-1:0] dal_in,
    output logic [asb_pkg::DAL_W-1:0]     dal_out,
    output logic                          dal_oe_out
);
    import asb_pkg::*;

    typedef enum logic [3:0] {
        ST_INIT, ST_IDLE, ST_ADDR, ST_HOLD, ST_RD_WAIT, ST_RD_REL,
        ST_WR_SETUP, ST_WR_WAIT, ST_WR_REL, ST_IAK_WAIT, ST_IAK_REL, ST_FIN
    } asb_st_type;

    typedef struct packed {
        asb_st_type        st;
        asb_cmd_type       cmd;
        logic [DAL_W-1:0]  addr;
        logic [DAL_W-1:0]  wdata;
        logic [11:0]       cnt;
        asb_ctl_type       ctl;
        logic [DAL_W-1:0]  dal;
        logic              oe;
        logic [DAL_W-1:0]  rdata;
        logic [DAL_W-1:0]  vec;
        logic              done;
        logic              err;
        logic              vec_valid;
        logic              iak;
    } asb_state_type;

    localparam logic [11:0] TMO = 12'(TMO_CYC);

    asb_state_type s;
    asb_state_type next_s;

    logic is_write;
    logic is_byte;
    logic is_rmw;
    logic iak_cond;
    logic in_bank7;

    assign is_write = (s.cmd == CMD_DATO) || (s.cmd == CMD_DATOB);        // [R13]
    assign is_byte  = (s.cmd == CMD_DATOB) || (s.cmd == CMD_DATIOB);
    assign is_rmw   = (s.cmd == CMD_DATIO) || (s.cmd == CMD_DATIOB);
    assign iak_cond = !irq_n_in && !processor_status_word_in[PSW_PRIO_BIT];     // [R02]
    assign in_bank7 = (req_in.addr[15:13] == BANK7_TOP);

    always_comb begin
        next_s           = s;
        next_s.done      = 1'b0;
        next_s.err       = 1'b0;
        next_s.vec_valid = 1'b0;
        if (s.cnt != 12'h000) begin
            next_s.cnt = s.cnt - 12'h001;
        end
        case (s.st)
            ST_INIT: begin
                if (s.cnt == 12'h000) begin
                    next_s.ctl.init_n = 1'b1;
                    next_s.st         = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (init_req_in) begin
                    next_s.ctl.init_n = 1'b0;                                   // [R21]
                    next_s.cnt        = INIT_CYC;
                    next_s.st         = ST_INIT;
                end else if (iak_cond) begin
                    // Data-in without sync marks the acknowledge
                    next_s.ctl.din_n  = 1'b0;                                   // [R02]
                    next_s.ctl.iako_n = 1'b0;
                    next_s.iak        = 1'b1;
                    next_s.cnt        = TMO;
                    next_s.st         = ST_IAK_WAIT;
                end else if (req_valid_in) begin
                    next_s.cmd        = req_in.cmd;
                    next_s.addr       = req_in.addr;
                    next_s.wdata      = req_in.wdata;
                    next_s.iak        = 1'b0;
                    next_s.dal        = req_in.addr;                            // [R12]
                    next_s.oe         = 1'b1;
                    next_s.ctl.bs7_n  = !in_bank7;                              // [R04]
                    next_s.ctl.wtbt_n = !((req_in.cmd == CMD_DATO) ||
                                          (req_in.cmd == CMD_DATOB));           // [R09]
                    next_s.cnt        = ADDR_SETUP_CYC;
                    next_s.st         = ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (s.cnt <= 12'h001) begin
                    next_s.ctl.sync_n = 1'b0;                                   // [R05]
                    next_s.cnt        = ADDR_HOLD_CYC;
                    next_s.st         = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (s.cnt <= 12'h001) begin
                    next_s.ctl.bs7_n = 1'b1;
                    if (is_write) begin
                        next_s.dal        = s.wdata;
                        next_s.ctl.wtbt_n = !is_byte;                           // [R10]
                        next_s.cnt        = DESKEW_CYC;
                        next_s.st         = ST_WR_SETUP;
                    end else begin
                        // Release lines in the same cycle as asking for data
                        next_s.oe         = 1'b0;                               // [R12]
                        next_s.ctl.wtbt_n = 1'b1;
                        next_s.ctl.din_n  = 1'b0;                               // [R06]
                        next_s.cnt        = TMO;
                        next_s.st         = ST_RD_WAIT;
                    end
                end
            end
            ST_RD_WAIT: begin
                if (!rply_n_in) begin
                    next_s.rdata     = dal_in;                                  // [R25]
                    next_s.ctl.din_n = 1'b1;
                    next_s.cnt       = TMO;
                    next_s.st        = ST_RD_REL;
                end else if (s.cnt == 12'h000) begin
                    next_s.err       = 1'b1;
                    next_s.ctl.din_n = 1'b1;
                    next_s.st        = ST_FIN;
                end
            end
            ST_RD_REL: begin
                if (rply_n_in) begin
                    if (is_rmw) begin
                        // Device stays selected, no new address
                        next_s.dal        = s.wdata;                            // [R14]
                        next_s.oe         = 1'b1;
                        next_s.ctl.wtbt_n = !is_byte;                           // [R10]
                        next_s.cnt        = DESKEW_CYC;
                        next_s.st         = ST_WR_SETUP;
                    end else begin
                        next_s.st = ST_FIN;
                    end
                end else if (s.cnt == 12'h000) begin
                    next_s.err = 1'b1;
                    next_s.st  = ST_FIN;
                end
            end
            ST_WR_SETUP: begin
                if (s.cnt <= 12'h001) begin
                    next_s.ctl.dout_n = 1'b0;                                   // [R08]
                    next_s.cnt        = TMO;
                    next_s.st         = ST_WR_WAIT;
                end
            end
            ST_WR_WAIT: begin
                if (!rply_n_in || s.cnt == 12'h000) begin
                    next_s.err        = rply_n_in;
                    next_s.ctl.dout_n = 1'b1;
                    next_s.cnt        = TMO;
                    next_s.st         = rply_n_in ? ST_FIN : ST_WR_REL;
                end
            end
            ST_WR_REL: begin
                if (rply_n_in || s.cnt == 12'h000) begin
                    next_s.err = !rply_n_in;
                    next_s.st  = ST_FIN;
                end
            end
            ST_IAK_WAIT: begin
                if (!rply_n_in || s.cnt == 12'h000) begin
                    next_s.vec        = dal_in;
                    next_s.err        = rply_n_in;
                    next_s.ctl.din_n  = 1'b1;
                    next_s.ctl.iako_n = 1'b1;
                    next_s.cnt        = TMO;
                    next_s.st         = rply_n_in ? ST_FIN : ST_IAK_REL;
                end
            end
            ST_IAK_REL: begin
                if (rply_n_in || s.cnt == 12'h000) begin
                    next_s.err = !rply_n_in;
                    next_s.st  = ST_FIN;
                end
            end
            ST_FIN: begin
                next_s.ctl.sync_n = 1'b1;                                       // [R05]
                next_s.ctl.wtbt_n = 1'b1;
                next_s.ctl.bs7_n  = 1'b1;
                next_s.oe         = 1'b0;
                next_s.done       = !s.iak;
                next_s.vec_valid  = s.iak;
                next_s.st         = ST_IDLE;
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s            <= '0;
            s.st         <= ST_INIT;
            s.ctl        <= CTL_IDLE;
            s.ctl.init_n <= 1'b0;                                               // [R21]
            s.cnt        <= INIT_CYC;
        end else begin
            s <= next_s;
        end
    end

    assign req_ready_out = (s.st == ST_IDLE) && !init_req_in && !iak_cond;
    assign done_out      = s.done;
    assign err_out       = s.err;
    assign rdata_out     = s.rdata;
    assign vec_valid_out = s.vec_valid;
    assign vec_out       = s.vec;
    assign ctl_out       = s.ctl;
    assign dal_out       = s.dal;
    assign dal_oe_out    = s.oe;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);

    sequence sync_edge;
        $fell(s.ctl.sync_n);
    endsequence

    sequence dout_edge;
        $fell(s.ctl.dout_n);
    endsequence

    a_sync_with_addr: assert property (sync_edge |-> s.oe && s.dal == s.addr)   // [R05]
        else $error("sync asserted without address on the lines");
    a_bank7_select: assert property (sync_edge |->
            (s.ctl.bs7_n == (s.addr[15:13] != BANK7_TOP)))                       // [R04]
        else $error("bank-7 select wrong at sync");
    a_wtbt_announce: assert property (sync_edge |-> (s.ctl.wtbt_n == !is_write)) // [R09]
        else $error("write/byte wrong at sync edge");
    a_read_no_drive: assert property (!s.ctl.din_n |-> !s.oe)                    // [R12]
        else $error("host drives lines during data-in");
    a_dout_deskew: assert property (dout_edge |->
            s.oe && $past(s.oe, 2) && $stable(s.dal))                            // [R08]
        else $error("data-out without settled data");
    a_byte_wtbt: assert property (dout_edge |-> (s.ctl.wtbt_n == !is_byte))      // [R10]
        else $error("write/byte wrong during data-out");
    a_iak_pairing: assert property (!s.ctl.iako_n |-> !s.ctl.din_n && s.ctl.sync_n) // [R02]
        else $error("acknowledge without data-in or with sync");
    a_rmw_keeps_sync: assert property ((s.st == ST_RD_REL && is_rmw && rply_n_in)
            |=> !s.ctl.sync_n [*2] ##1 (s.st == ST_WR_SETUP || !s.ctl.dout_n)) // [R14]
        else $error("sync dropped inside read-modify-write");
    a_init_hold: assert property ($fell(s.ctl.init_n) |-> !s.ctl.init_n [*8])    // [R21]
        else $error("initialize pulse too short");
    a_read_strobe: assert property ((s.st == ST_HOLD && !is_write && s.cnt <= 12'h001)
            |=> !s.ctl.din_n && !s.ctl.sync_n && s.ctl.bs7_n)                    // [R06]
        else $error("read data-in not raised after address");
endmodule : asb_host
`default_nettype wire

/* File: include/asb_pkg.sv */
// What the document requires (R15-R20 not modelled here)
// R01: Device asserts interrupt request only with its enable and request flops set.
// R02: Host grants a request, priority bit clear, with data-in plus outgoing acknowledge.
// R03: Device passes acknowledge downstream unless it is requesting itself.
// R04: Host asserts bank-7 select for top 4K-word addresses through addressing.
// R05: Host asserts sync once address is driven, holds it until transfer ends.
// R06: Host asserts data-in within sync when ready; device answers with reply.
// R07: Data-in without sync means interrupt acknowledge, not a register read.
// R08: Host asserts data-out only with stable, deskewed write data; device replies.
// R09: Host asserts write/byte at sync leading edge to announce a write.
// R10: Host asserts write/byte during data-out of a byte write.
// R11: Device replies to data-in, data-out and interrupt acknowledge.
// R12: Shared lines carry address then data; device drives reads after address removal.
// R13: Both ends support word read, word write and byte write cycles.
// R14: Read-modify-write keeps sync asserted; write follows without new address.
// R15: Device requests receive service at 1 or 16 silo characters.
// R16: Device requests transmit service for empty line, reports line number.
// R17: Device buffers received characters in a silo with receive scanner.
// R18: Device generates bit clocks with selected rate and character format.
// R19: Device forces per-line break on its serial outputs under control.
// R20: Device loops serial outputs back to inputs in maintenance mode.
// R21: Host asserts bus initialize, also at power-up; device clears meanwhile.
// R22: Device decodes address bits 03 to 12 only while bank-7 select active.
// R23: Device drives vector bit 02 high for transmit, low for receive.
// R24: Device releases reply only after host negates data-in.
// R25: Device accepts word and byte writes, always returns full words.
// R26: Device synchronises bus strobes before using them; the model uses them directly, delaying sync only for edge detection.
`default_nettype none
package asb_pkg;
    localparam int CLK_NS         = 100;
    localparam int ADDR_SETUP_NS  = 150;
    localparam int ADDR_HOLD_NS   = 100;
    localparam int DESKEW_NS      = 150;
    localparam int RPLY_TMO_NS    = 10000;
    localparam int INIT_NS        = 10000;
    localparam logic [11:0] ADDR_SETUP_CYC = 12'((ADDR_SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] ADDR_HOLD_CYC  = 12'((ADDR_HOLD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] DESKEW_CYC     = 12'((DESKEW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] RPLY_TMO_CYC   = 12'(RPLY_TMO_NS / CLK_NS);
    localparam logic [11:0] INIT_CYC       = 12'((INIT_NS + CLK_NS - 1) / CLK_NS);
    localparam int          PSW_PRIO_BIT   = 7;
    localparam logic [2:0]  BANK7_TOP      = 3'h7;
    localparam int          DAL_W          = 16;

    typedef enum logic [2:0] {
        CMD_DATI, CMD_DATO, CMD_DATOB, CMD_DATIO, CMD_DATIOB
    } asb_cmd_type;

    typedef struct packed {
        asb_cmd_type       cmd;
        logic [DAL_W-1:0]  addr;
        logic [DAL_W-1:0]  wdata;
    } asb_req_type;

    // Bus control strobes, all active low on the backplane
    typedef struct packed {
        logic init_n;
        logic sync_n;
        logic din_n;
        logic dout_n;
        logic wtbt_n;
        logic bs7_n;
        logic iako_n;
    } asb_ctl_type;

    localparam asb_ctl_type CTL_IDLE = 7'h7F;
endpackage : asb_pkg
`default_nettype wire

/* File: testbench/asb_dev_model.sv */
`default_nettype none
module asb_dev_model
    import asb_pkg::*;
#(
    parameter logic [15:0] BASE = 16'hFE40
) (
    input  wire logic        clk_in,
    input  wire asb_ctl_type ctl_in,
    input  wire logic [15:0] dal_in,
    input  wire logic [3:0]  dly_in,
    input  wire logic        ie_in,
    input  wire logic        raise_in,
    input  wire logic        tx_in,
    output logic [15:0]      dal_out,
    output logic             dal_oe_out,
    output logic             rply_n_out,
    output logic             irq_n_out,
    output logic             iako_n_out,
    output var int           phases_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [4];
    logic [15:0] addr;
    logic        sel;
    logic        wr;
    logic        ir;
    logic        sync_d;
    logic [3:0]  cnt;
    assign irq_n_out  = !(ie_in && ir);
    assign iako_n_out = irq_n_out ? ctl_in.iako_n : 1'b1;
    always @(posedge clk_in) begin
        sync_d <= ctl_in.sync_n;
        if (!ctl_in.init_n) begin
            mem <= '{default: 16'h0000};
            ir <= 1'b0;
            sel <= 1'b0;
            rply_n_out <= 1'b1;
            dal_oe_out <= 1'b0;
            dal_out <= 16'hA5A5;
            cnt <= 4'h0;
            phases_out <= 0;
        end else begin
            if (raise_in) ir <= 1'b1;
            if (sync_d && !ctl_in.sync_n) begin
                addr <= dal_in;
                sel <= !ctl_in.bs7_n && dal_in[12:3] == BASE[12:3];
                wr <= !ctl_in.wtbt_n;
                phases_out <= phases_out + 1;
            end
            if (ctl_in.din_n && ctl_in.dout_n) begin
                rply_n_out <= 1'b1;
                dal_oe_out <= 1'b0;
                cnt <= 4'h0;
                dal_out <= ~dal_out;
            end else if (cnt < dly_in) begin
                cnt <= cnt + 4'h1;
            end else if (rply_n_out) begin
                if (ctl_in.sync_n && !ctl_in.iako_n && !irq_n_out) begin
                    dal_out <= {13'h0000, tx_in, 2'b00};
                    dal_oe_out <= 1'b1;
                    rply_n_out <= 1'b0;
                    ir <= 1'b0;
                end else if (!ctl_in.sync_n && !ctl_in.din_n && sel && !wr) begin
                    dal_out <= mem[addr[2:1]];
                    dal_oe_out <= 1'b1;
                    rply_n_out <= 1'b0;
                end else if (!ctl_in.sync_n && !ctl_in.dout_n && sel) begin
                    if (ctl_in.wtbt_n || !addr[0]) mem[addr[2:1]][7:0] <= dal_in[7:0];
                    if (ctl_in.wtbt_n || addr[0]) mem[addr[2:1]][15:8] <= dal_in[15:8];
                    rply_n_out <= 1'b0;
                end
            end
        end
    end
endmodule : asb_dev_model
`default_nettype wire

/* File: testbench/async_mux_backplane_slave_port_test.sv */
`default_nettype none
module async_mux_backplane_slave_port_test;
    import asb_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in = 0, nrst_in = 0, req_valid = 0, ie = 0, raise = 0, tx = 0;
    logic        ready, done, err, vec_valid, dal_oe, dev_oe, rply_n, irq_n, e;
    logic [15:0] processor_status_word = 16'h0000, rdata, vec, host_dal, dev_dal, bus;
    logic [3:0]  dly = 4'h0;
    asb_req_type req = '0;
    asb_ctl_type ctl;
    int          num_errors = 0, checks_done = 0, cycles = 0, vecs = 0, overlap = 0, phases, p0;
    always #50 clk_in = ~clk_in;
    assign bus = dal_oe ? host_dal : dev_dal;
    asb_host #(.TMO_CYC(8)) i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .init_req_in(1'b0),
        .req_valid_in(req_valid), .req_in(req), .req_ready_out(ready), .done_out(done),
        .err_out(err), .rdata_out(rdata), .processor_status_word_in(processor_status_word),
        .vec_valid_out(vec_valid), .vec_out(vec), .ctl_out(ctl), .rply_n_in(rply_n),
        .irq_n_in(irq_n), .dal_in(bus), .dal_out(host_dal), .dal_oe_out(dal_oe));
    asb_dev_model i_dev (.clk_in(clk_in), .ctl_in(ctl), .dal_in(bus), .dly_in(dly),
        .ie_in(ie), .raise_in(raise), .tx_in(tx), .dal_out(dev_dal), .dal_oe_out(dev_oe),
        .rply_n_out(rply_n), .irq_n_out(irq_n), .iako_n_out(), .phases_out(phases));
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end
    always @(negedge clk_in) begin
        if (dal_oe === 1'b1 && dev_oe === 1'b1) overlap++;
        if (vec_valid === 1'b1) vecs++;
    end
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic xfer(input asb_cmd_type cmd, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_in);
        req_valid <= 1'b1;
        req <= '{cmd: cmd, addr: a, wdata: d};
        do @(negedge clk_in); while (ready !== 1'b1);
        @(posedge clk_in);
        req_valid <= 1'b0;
        e = 1'bx;
        for (int n = 0; n < 200; n++) begin
            @(negedge clk_in);
            // Error pulse comes the cycle before done
            if (err === 1'b1) e = 1'b1;
            if (done === 1'b1) begin
                if (e !== 1'b1) e = 1'b0;
                break;
            end
        end
    endtask : xfer
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        xfer(CMD_DATI, a, 16'h0000);
        chk("read err", {15'h0, e}, 16'h0000);
        chk("read data", rdata, exp);
    endtask : rd
    task automatic t_init();
        repeat (50) @(negedge clk_in);
        chk("init held", {15'h0, ctl.init_n}, 16'h0000);
        repeat (60) @(negedge clk_in);
        chk("init done", {15'h0, ctl.init_n}, 16'h0001);
        rd(16'hFE40, 16'h0000);
    endtask : t_init
    task automatic t_words();
        xfer(CMD_DATO, 16'hFE40, 16'h1234);
        chk("dato err", {15'h0, e}, 16'h0000);
        xfer(CMD_DATO, 16'hFE42, 16'h5678);
        rd(16'hFE40, 16'h1234);
        rd(16'hFE42, 16'h5678);
        xfer(CMD_DATOB, 16'hFE41, 16'hAB00);
        xfer(CMD_DATOB, 16'hFE42, 16'h0099);
        rd(16'hFE40, 16'hAB34);
        rd(16'hFE42, 16'h5699);
    endtask : t_words
    task automatic t_rmw();
        p0 = phases;
        xfer(CMD_DATIO, 16'hFE40, 16'h0F0F);
        chk("rmw old", rdata, 16'hAB34);
        chk("rmw phases", 16'(phases - p0), 16'h0001);
        xfer(CMD_DATIOB, 16'hFE43, 16'hC300);
        chk("rmwb old", rdata, 16'h5699);
        rd(16'hFE40, 16'h0F0F);
        rd(16'hFE42, 16'hC399);
    endtask : t_rmw
    task automatic t_miss_slow();
        xfer(CMD_DATI, 16'h1E40, 16'h0000);
        chk("no bank7 err", {15'h0, e}, 16'h0001);
        xfer(CMD_DATO, 16'hFE80, 16'hFFFF);
        chk("mismatch err", {15'h0, e}, 16'h0001);
        dly <= 4'h5;
        xfer(CMD_DATO, 16'hFE44, 16'h3C3C);
        chk("slow write err", {15'h0, e}, 16'h0000);
        rd(16'hFE44, 16'h3C3C);
        dly <= 4'hC;
        xfer(CMD_DATI, 16'hFE44, 16'h0000);
        chk("late reply err", {15'h0, e}, 16'h0001);
        dly <= 4'h0;
    endtask : t_miss_slow
    task automatic t_irq(input logic t, input logic [15:0] exp);
        @(posedge clk_in);
        tx <= t;
        raise <= 1'b1;
        @(posedge clk_in);
        raise <= 1'b0;
        repeat (30) @(negedge clk_in);
        chk("masked grant", 16'(vecs), 16'h0000);
        processor_status_word <= 16'h0000;
        for (int n = 0; n < 100 && vecs == 0; n++) @(negedge clk_in);
        chk("vector count", 16'(vecs), 16'h0001);
        chk("vector", vec, exp);
        vecs = 0;
        processor_status_word <= 16'h0080;
        rd(16'hFE44, 16'h3C3C);
    endtask : t_irq
    task automatic results();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    initial begin
        repeat (5) @(posedge clk_in);
        nrst_in <= 1'b1;
        t_init();
        t_words();
        t_rmw();
        t_miss_slow();
        processor_status_word <= 16'h0080;
        ie <= 1'b1;
        t_irq(1'b1, 16'h0004);
        t_irq(1'b0, 16'h0000);
        ie <= 1'b0;
        processor_status_word <= 16'h0000;
        raise <= 1'b1;
        @(posedge clk_in);
        raise <= 1'b0;
        repeat (30) @(negedge clk_in);
        chk("disabled irq", 16'(vecs), 16'h0000);
        chk("bus overlap", 16'(overlap), 16'h0000);
        results();
    end
endmodule : async_mux_backplane_slave_port_test
`default_nettype wire
